// file: verilog/fcrc_consts.vh
// Constants for the frame check unit: offsets, fields, presets, codes.
`ifndef FCRC_CONSTS_VH
`define FCRC_CONSTS_VH

// ==========================================================================
// Register offsets (byte-wide registers on a plain port).
`define FCRC_ADDR_TX_SETUP   8'h2C
`define FCRC_ADDR_RX_SETUP   8'h2D
`define FCRC_ADDR_IRQ_STATUS 8'h40
`define FCRC_ADDR_IRQ_MASK   8'h41

// ==========================================================================
// Field positions of both setup registers; the force bit is on receive only.
`define FCRC_F_ENABLE        0
`define FCRC_F_INVERT        1
`define FCRC_F_TYPE_LO       2
`define FCRC_F_TYPE_HI       3
`define FCRC_F_PRESET_LO     4
`define FCRC_F_PRESET_HI     6
`define FCRC_F_FORCE_WRITE   7

// Writable bits: the top bit of the transmit register is reserved.
`define FCRC_TX_SETUP_MASK   8'h7F
`define FCRC_RX_SETUP_MASK   8'hFF
`define FCRC_SETUP_RESET     8'h00

// ==========================================================================
// Interrupt status bits.
`define FCRC_IRQ_CRC_ERR     0
`define FCRC_IRQ_TX_DONE     1
`define FCRC_IRQ_RX_DONE     2
`define FCRC_IRQ_BITS        3

// ==========================================================================
// Check width codes.
`define FCRC_TYPE_CRC5       2'h0
`define FCRC_TYPE_CRC8       2'h1
`define FCRC_TYPE_CRC16      2'h2
`define FCRC_TYPE_RSVD       2'h3

// ==========================================================================
// Start value codes and the fixed start values.
`define FCRC_PSEL_0          3'h0
`define FCRC_PSEL_1          3'h1
`define FCRC_PSEL_2          3'h2
`define FCRC_PSEL_3          3'h3
`define FCRC_PSEL_USER       3'h6
`define FCRC_PSEL_7          3'h7
`define FCRC_P16_0           16'h0000
`define FCRC_P16_1           16'h6363
`define FCRC_P16_2           16'hA671
`define FCRC_P16_3           16'hFFFE
`define FCRC_P16_7           16'hFFFF
`define FCRC_P8_0            8'h00
`define FCRC_P8_1            8'h12
`define FCRC_P8_2            8'hBF
`define FCRC_P8_3            8'hFD
`define FCRC_P8_7            8'hFF
`define FCRC_P5_0            5'h00
`define FCRC_P5_1            5'h12
`define FCRC_P5_7            5'h1F
`define FCRC_P_UNDEF         16'h0000

// ==========================================================================
// Reflected generator polynomials for least significant bit first shifting.
`define FCRC_POLY16          16'h8408
`define FCRC_POLY8           16'h00B8
`define FCRC_POLY5           16'h0014

`endif

// file: verilog/fcrc_unit.v
// Transmit and receive frame check unit with its registers and interrupt.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Transmit enable set appends check to frame.
// - Width code selects CRC5, CRC8 or CRC16.
// - Transmit invert bit inverts appended check value.
// - Transmit start selector loads start value.
// - Start code table per width, transmit side.
// - Receive uses the same start code table.
// - Code six takes user value from memory.
// - Receive start selector loads start value.
// - Force bit copies received check bytes onward.
// - Receive invert compares against inverted check.
// - Receive enable checks and flags a mismatch.
// - Receive disabled computes but leaves flag alone.
`include "fcrc_consts.vh"

module fcrc_unit (
  clk,
  rstn,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  irq,
  user_start16,
  user_start8,
  user_start5,
  tx_frame_start,
  tx_byte_valid,
  tx_byte,
  tx_frame_end,
  tx_ready,
  tx_out_valid,
  tx_out_byte,
  tx_frame_done,
  rx_frame_start,
  rx_byte_valid,
  rx_byte,
  rx_byte_is_check,
  rx_frame_end,
  fifo_wr_valid,
  fifo_wr_byte,
  rx_frame_done,
  rx_crc_error
);

  input  wire        clk;              // System clock, 100 MHz.
  input  wire        rstn;             // Asynchronous reset, active low.
  input  wire [7:0]  reg_addr;         // Register address.
  input  wire [7:0]  reg_wdata;        // Register write data.
  input  wire        reg_wr;           // Write strobe.
  input  wire        reg_rd;           // Read strobe.
  output reg  [7:0]  reg_rdata;        // Read data, one cycle after strobe.
  output wire        irq;              // Level interrupt.
  input  wire [15:0] user_start16;     // User start value, CRC16.
  input  wire [7:0]  user_start8;      // User start value, CRC8.
  input  wire [4:0]  user_start5;      // User start value, CRC5.
  input  wire        tx_frame_start;   // Pulse: a new outgoing frame.
  input  wire        tx_byte_valid;    // Outgoing data byte offered.
  input  wire [7:0]  tx_byte;          // Outgoing data byte.
  input  wire        tx_frame_end;     // Pulse: outgoing data complete.
  output wire        tx_ready;         // Low while check bytes go out.
  output reg         tx_out_valid;     // Byte on tx_out_byte is valid.
  output reg  [7:0]  tx_out_byte;      // Outgoing byte stream.
  output reg         tx_frame_done;    // Pulse: frame fully sent.
  input  wire        rx_frame_start;   // Pulse: a new received frame.
  input  wire        rx_byte_valid;    // Received byte offered.
  input  wire [7:0]  rx_byte;          // Received byte.
  input  wire        rx_byte_is_check; // Received byte is a check byte.
  input  wire        rx_frame_end;     // Pulse: received frame complete.
  output reg         fifo_wr_valid;    // Byte write towards the FIFO.
  output reg  [7:0]  fifo_wr_byte;     // Byte written to the FIFO.
  output reg         rx_frame_done;    // Pulse: received frame closed.
  output reg         rx_crc_error;     // Pulse: mismatch found.

  // ========================================================================
  // Functions

  // Start value for a width and selector code; undefined codes give zero.
  function [15:0] start_value;
    input [1:0]  ctype;
    input [2:0]  sel;
    input [15:0] u16;
    input [7:0]  u8;
    input [4:0]  u5;
    begin
      start_value = `FCRC_P_UNDEF;
      if (sel == `FCRC_PSEL_USER) begin
        // User values come from nonvolatile configuration.
        if (ctype == `FCRC_TYPE_CRC5)
          start_value = {11'h000, u5};
        else if (ctype == `FCRC_TYPE_CRC8)
          start_value = {8'h00, u8};
        else
          start_value = u16;
      end else if (ctype == `FCRC_TYPE_CRC5) begin
        case (sel)
          `FCRC_PSEL_0: start_value = {11'h000, `FCRC_P5_0};
          `FCRC_PSEL_1: start_value = {11'h000, `FCRC_P5_1};
          `FCRC_PSEL_7: start_value = {11'h000, `FCRC_P5_7};
          default:      start_value = `FCRC_P_UNDEF;
        endcase
      end else if (ctype == `FCRC_TYPE_CRC8) begin
        case (sel)
          `FCRC_PSEL_0: start_value = {8'h00, `FCRC_P8_0};
          `FCRC_PSEL_1: start_value = {8'h00, `FCRC_P8_1};
          `FCRC_PSEL_2: start_value = {8'h00, `FCRC_P8_2};
          `FCRC_PSEL_3: start_value = {8'h00, `FCRC_P8_3};
          `FCRC_PSEL_7: start_value = {8'h00, `FCRC_P8_7};
          default:      start_value = `FCRC_P_UNDEF;
        endcase
      end else begin
        case (sel)
          `FCRC_PSEL_0: start_value = `FCRC_P16_0;
          `FCRC_PSEL_1: start_value = `FCRC_P16_1;
          `FCRC_PSEL_2: start_value = `FCRC_P16_2;
          `FCRC_PSEL_3: start_value = `FCRC_P16_3;
          `FCRC_PSEL_7: start_value = `FCRC_P16_7;
          default:      start_value = `FCRC_P_UNDEF;
        endcase
      end
    end
  endfunction

  // Mask of the live check bits; the reserved code acts as CRC16.
  function [15:0] width_mask;
    input [1:0] ctype;
    begin
      case (ctype)
        `FCRC_TYPE_CRC5: width_mask = 16'h001F;
        `FCRC_TYPE_CRC8: width_mask = 16'h00FF;
        default:         width_mask = 16'hFFFF;
      endcase
    end
  endfunction

  // One byte through the register, least significant bit first.
  // Narrow widths keep their state in the low bits, so one shifter serves.
  function [15:0] crc_byte;
    input [15:0] crc;
    input [7:0]  data;
    input [1:0]  ctype;
    integer      i;
    reg   [15:0] c;
    reg   [15:0] poly;
    begin
      c = crc;
      case (ctype)
        `FCRC_TYPE_CRC5: poly = `FCRC_POLY5;
        `FCRC_TYPE_CRC8: poly = `FCRC_POLY8;
        default:         poly = `FCRC_POLY16;
      endcase
      for (i = 0; i < 8; i = i + 1) begin
        if (c[0] ^ data[i])
          c = (c >> 1) ^ poly;
        else
          c = c >> 1;
      end
      crc_byte = c;
    end
  endfunction

  // ========================================================================
  // Registers

  reg [7:0]               tx_setup_q; // Transmit check setup.
  reg [7:0]               rx_setup_q; // Receive check setup.
  reg [`FCRC_IRQ_BITS-1:0] status_q;  // Sticky event bits.
  reg [`FCRC_IRQ_BITS-1:0] mask_q;    // Interrupt mask.
  reg [`FCRC_IRQ_BITS-1:0] events;    // Events raised this cycle.

  wire [1:0] tx_type = tx_setup_q[`FCRC_F_TYPE_HI:`FCRC_F_TYPE_LO];
  wire [1:0] rx_type = rx_setup_q[`FCRC_F_TYPE_HI:`FCRC_F_TYPE_LO];
  wire [2:0] tx_psel = tx_setup_q[`FCRC_F_PRESET_HI:`FCRC_F_PRESET_LO];
  wire [2:0] rx_psel = rx_setup_q[`FCRC_F_PRESET_HI:`FCRC_F_PRESET_LO];

  // Register writes; a set event wins over a write-one clear.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_setup_q <= `FCRC_SETUP_RESET;
      rx_setup_q <= `FCRC_SETUP_RESET;
      status_q   <= {`FCRC_IRQ_BITS{1'b0}};
      mask_q     <= {`FCRC_IRQ_BITS{1'b0}};
    end else begin
      if (reg_wr && reg_addr == `FCRC_ADDR_TX_SETUP)
        tx_setup_q <= reg_wdata & `FCRC_TX_SETUP_MASK;
      if (reg_wr && reg_addr == `FCRC_ADDR_RX_SETUP)
        rx_setup_q <= reg_wdata & `FCRC_RX_SETUP_MASK;
      if (reg_wr && reg_addr == `FCRC_ADDR_IRQ_MASK)
        mask_q <= reg_wdata[`FCRC_IRQ_BITS-1:0];
      if (reg_wr && reg_addr == `FCRC_ADDR_IRQ_STATUS)
        status_q <= (status_q & ~reg_wdata[`FCRC_IRQ_BITS-1:0]) | events;
      else
        status_q <= status_q | events;
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads 0.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FCRC_ADDR_TX_SETUP:   reg_rdata <= tx_setup_q;
        `FCRC_ADDR_RX_SETUP:   reg_rdata <= rx_setup_q;
        `FCRC_ADDR_IRQ_STATUS: reg_rdata <= {5'h00, status_q};
        `FCRC_ADDR_IRQ_MASK:   reg_rdata <= {5'h00, mask_q};
        default:               reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign irq = |(status_q & mask_q);

  // ========================================================================
  // Transmit path

  localparam [1:0] TX_DATA = 2'b01; // Passing data, updating the check.
  localparam [1:0] TX_APP  = 2'b10; // Appending check bytes.

  reg  [1:0]  tx_state_q;  // One-hot state.
  reg  [15:0] tx_crc_q;    // Running check; final value when appending.
  reg  [1:0]  tx_left_q;   // Check bytes still to send.
  wire [15:0] tx_crc_upd = crc_byte(tx_crc_q, tx_byte, tx_type);
  wire [15:0] tx_crc_cur = (tx_byte_valid && tx_ready) ? tx_crc_upd
                                                       : tx_crc_q;
  wire [15:0] tx_final   = (tx_setup_q[`FCRC_F_INVERT] ? ~tx_crc_cur
                                                       : tx_crc_cur)
                           & width_mask(tx_type);

  // Holding off the source while appending avoids any buffer here.
  assign tx_ready = tx_state_q[0];

  // Transmit sequencer: pass data, then append the check, low byte first.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_q    <= TX_DATA;
      tx_crc_q      <= 16'h0000;
      tx_left_q     <= 2'h0;
      tx_out_valid  <= 1'b0;
      tx_out_byte   <= 8'h00;
      tx_frame_done <= 1'b0;
    end else begin
      tx_out_valid  <= 1'b0;
      tx_frame_done <= 1'b0;
      case (tx_state_q)
        TX_DATA: begin
          if (tx_frame_start) begin
            // Start value chosen by width and selector.
            tx_crc_q <= start_value(tx_type, tx_psel, user_start16,
                                    user_start8, user_start5);
          end else begin
            if (tx_byte_valid) begin
              tx_out_valid <= 1'b1;
              tx_out_byte  <= tx_byte;
              tx_crc_q     <= tx_crc_upd;
            end
            if (tx_frame_end) begin
              if (tx_setup_q[`FCRC_F_ENABLE]) begin
                // Append one byte, or two for the 16-bit check.
                tx_crc_q   <= tx_final;
                tx_left_q  <= (width_mask(tx_type) == 16'hFFFF) ? 2'h2
                                                                : 2'h1;
                tx_state_q <= TX_APP;
              end else begin
                tx_frame_done <= 1'b1;
              end
            end
          end
        end
        TX_APP: begin
          tx_out_valid <= 1'b1;
          tx_out_byte  <= tx_crc_q[7:0];
          tx_crc_q     <= {8'h00, tx_crc_q[15:8]};
          tx_left_q    <= tx_left_q - 2'h1;
          if (tx_left_q == 2'h1) begin
            tx_frame_done <= 1'b1;
            tx_state_q    <= TX_DATA;
          end
        end
        default: begin
          tx_state_q <= TX_DATA;
        end
      endcase
    end
  end

  // ========================================================================
  // Receive path

  reg  [15:0] rx_crc_q;  // Running check over data bytes.
  reg  [15:0] rx_chk_q;  // Received check bytes, first byte lowest.
  reg  [1:0]  rx_ncheck_q; // Number of check bytes seen.
  wire        rx_data_b  = rx_byte_valid && !rx_byte_is_check;
  wire        rx_check_b = rx_byte_valid && rx_byte_is_check;
  wire [15:0] rx_crc_cur = rx_data_b ? crc_byte(rx_crc_q, rx_byte, rx_type)
                                     : rx_crc_q;
  wire [15:0] rx_chk_cur = rx_check_b ? {rx_byte, rx_chk_q[15:8]}
                                      : rx_chk_q;
  wire [1:0]  rx_ncur    = rx_check_b ? rx_ncheck_q + 2'h1 : rx_ncheck_q;
  // A single check byte sits in the upper half after shifting in.
  wire [15:0] rx_got     = (rx_ncur == 2'h1) ? {8'h00, rx_chk_cur[15:8]}
                                             : rx_chk_cur;
  wire [15:0] rx_expect  = rx_setup_q[`FCRC_F_INVERT] ? ~rx_crc_cur
                                                      : rx_crc_cur;
  wire        rx_bad     = ((rx_expect ^ rx_got) & width_mask(rx_type))
                           != 16'h0000;
  wire        rx_err_now = rx_frame_end && rx_setup_q[`FCRC_F_ENABLE]
                           && rx_bad;

  // Receive checker: data always goes on, check bytes only when forced.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_crc_q      <= 16'h0000;
      rx_chk_q      <= 16'h0000;
      rx_ncheck_q   <= 2'h0;
      fifo_wr_valid <= 1'b0;
      fifo_wr_byte  <= 8'h00;
      rx_frame_done <= 1'b0;
      rx_crc_error  <= 1'b0;
    end else begin
      fifo_wr_valid <= rx_data_b || (rx_check_b &&
                       rx_setup_q[`FCRC_F_FORCE_WRITE]);
      if (rx_byte_valid)
        fifo_wr_byte <= rx_byte;
      rx_frame_done <= rx_frame_end;
      rx_crc_error  <= rx_err_now;
      if (rx_frame_start) begin
        // Same start table as transmit, own selector.
        rx_crc_q    <= start_value(rx_type, rx_psel, user_start16,
                                   user_start8, user_start5);
        rx_chk_q    <= 16'h0000;
        rx_ncheck_q <= 2'h0;
      end else begin
        // The check runs even when checking is off.
        rx_crc_q    <= rx_crc_cur;
        rx_chk_q    <= rx_chk_cur;
        rx_ncheck_q <= rx_ncur;
      end
    end
  end

  // Events feeding the sticky status bits.
  always @* begin
    events                      = {`FCRC_IRQ_BITS{1'b0}};
    events[`FCRC_IRQ_CRC_ERR]   = rx_err_now;
    events[`FCRC_IRQ_TX_DONE]   = tx_state_q[1] && tx_left_q == 2'h1;
    events[`FCRC_IRQ_RX_DONE]   = rx_frame_end;
  end

endmodule

// file: test/fcrc_unit_properties.sv
// Port-level assertions for the frame check unit.
`timescale 1ns/1ps
module fcrc_unit_props (
  input wire       clk,
  input wire       rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       irq,
  input wire       tx_byte_valid,
  input wire [7:0] tx_byte,
  input wire       tx_frame_end,
  input wire       tx_ready,
  input wire       tx_out_valid,
  input wire [7:0] tx_out_byte,
  input wire       tx_frame_done,
  input wire       rx_byte_valid,
  input wire [7:0] rx_byte,
  input wire       rx_byte_is_check,
  input wire       rx_frame_end,
  input wire       fifo_wr_valid,
  input wire [7:0] fifo_wr_byte,
  input wire       rx_frame_done,
  input wire       rx_crc_error
);
  // ==========================================================================
  // Shadow setup registers, rebuilt from bus writes so that the
  // assertions can see the mode without reaching into the design.
  reg [7:0] tx_cfg_q; // Transmit setup as last written.
  reg [7:0] rx_cfg_q; // Receive setup as last written.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_cfg_q <= 8'h00;
      rx_cfg_q <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h2C) begin
      tx_cfg_q <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h2D) begin
      rx_cfg_q <= reg_wdata;
    end
  end
  // ==========================================================================
  // Properties, all in the one clock domain.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_rd_slot_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  chk_tx_data_pass: assert property (tx_byte_valid && tx_ready |=>
    tx_out_valid && tx_out_byte == $past(tx_byte))
    else $error("accepted byte not passed on");
  chk_tx_wide_tail: assert property (tx_byte_valid && tx_ready &&
    tx_frame_end && tx_cfg_q[0] && tx_cfg_q[3]
    |=> !tx_ready && !tx_frame_done ##1 !tx_frame_done ##1 tx_frame_done)
    else $error("wide check tail has wrong length");
  chk_tx_narrow_tail: assert property (tx_byte_valid && tx_ready &&
    tx_frame_end && tx_cfg_q[0] && !tx_cfg_q[3]
    |=> !tx_frame_done ##1 tx_frame_done)
    else $error("narrow check tail has wrong length");
  chk_tx_no_append: assert property (tx_frame_end && !tx_cfg_q[0]
    |=> tx_frame_done) else $error("plain frame not closed at once");
  chk_rx_done_next: assert property (rx_frame_end |=> rx_frame_done)
    else $error("receive frame not closed");
  chk_rx_err_cause: assert property (rx_crc_error |->
    $past(rx_frame_end) && $past(rx_cfg_q[0]))
    else $error("error pulse without an enabled frame end");
  chk_rx_flag_kept: assert property (rx_frame_end && !rx_cfg_q[0]
    |=> !rx_crc_error) else $error("error raised while check disabled");
  chk_fifo_check_drop: assert property (rx_byte_valid &&
    rx_byte_is_check && !rx_cfg_q[7] |=> !fifo_wr_valid)
    else $error("check byte stored while copy is off");
  chk_fifo_check_copy: assert property (rx_byte_valid &&
    rx_byte_is_check && rx_cfg_q[7]
    |=> fifo_wr_valid && fifo_wr_byte == $past(rx_byte))
    else $error("check byte not stored while copy is on");
  chk_irq_mask_off: assert property (reg_wr && reg_addr == 8'h41 &&
    reg_wdata == 8'h00 |=> !irq) else $error("irq high with mask cleared");
endmodule
bind fcrc_unit fcrc_unit_props u_props (.clk, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .irq, .tx_byte_valid, .tx_byte, .tx_frame_end,
  .tx_ready, .tx_out_valid, .tx_out_byte, .tx_frame_done, .rx_byte_valid,
  .rx_byte, .rx_byte_is_check, .rx_frame_end, .fifo_wr_valid, .fifo_wr_byte,
  .rx_frame_done, .rx_crc_error);

// file: test/fcrc_unit_bench.sv
// Self-checking bench for the frame check unit.
`timescale 1ns/1ps
module fcrc_unit_bench;
  // ==========================================================================
  // Stimulus, observation and bookkeeping.
  reg        clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
  reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tx_byte = 8'h00;
  reg  [7:0] rx_byte = 8'h00, v = 8'h00;
  reg        tx_frame_start = 0, tx_byte_valid = 0, tx_frame_end = 0;
  reg        rx_frame_start = 0, rx_byte_valid = 0, rx_frame_end = 0;
  reg        rx_byte_is_check = 0;
  reg [15:0] user_start16 = 16'h1D0F; // User start values, picked freely.
  reg  [7:0] user_start8 = 8'h5A;
  reg  [4:0] user_start5 = 5'h0B;
  wire [7:0] reg_rdata, tx_out_byte, fifo_wr_byte;
  wire       irq, tx_ready, tx_out_valid, tx_frame_done;
  wire       fifo_wr_valid, rx_frame_done, rx_crc_error;
  integer    n_errors = 0, samples_checked = 0, cycles = 0, n_bad = 0;
  integer    t, s;
  reg  [7:0] txq[$], fq[$]; // Bytes seen on the two output streams.

  fcrc_unit u_fcrc_unit (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .user_start16, .user_start8, .user_start5,
    .tx_frame_start, .tx_byte_valid, .tx_byte, .tx_frame_end, .tx_ready,
    .tx_out_valid, .tx_out_byte, .tx_frame_done, .rx_frame_start,
    .rx_byte_valid, .rx_byte, .rx_byte_is_check, .rx_frame_end,
    .fifo_wr_valid, .fifo_wr_byte, .rx_frame_done, .rx_crc_error);

  always #5 clk = ~clk;
  // Collect output bytes and error pulses; cut a hang short.
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (tx_out_valid) txq.push_back(tx_out_byte);
    if (fifo_wr_valid) fq.push_back(fifo_wr_byte);
    if (rx_crc_error) n_bad = n_bad + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      conclude;
    end
  end
  // ==========================================================================
  // Shared helpers: compare, bus cycles, reference check value.
  task check(input [15:0] seen, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    reg_rd <= 1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 v = reg_rdata; // Data stands only in this one cycle.
  endtask
  function [15:0] wmask(input [1:0] ty);
    wmask = ty == 0 ? 16'h001F : ty == 1 ? 16'h00FF : 16'hFFFF;
  endfunction
  // Start value per width and code; undefined codes load zero.
  function [15:0] start_val(input [1:0] ty, input [2:0] sel);
    reg [15:0] a16[0:7], a8[0:7], a5[0:7];
    begin
      a16 = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFE, 0, 0, user_start16,
        16'hFFFF};
      a8 = '{8'h00, 8'h12, 8'hBF, 8'hFD, 0, 0, user_start8, 8'hFF};
      a5 = '{5'h00, 5'h12, 0, 0, 0, 0, user_start5, 5'h1F};
      start_val = ty == 0 ? a5[sel] : ty == 1 ? a8[sel] : a16[sel];
    end
  endfunction
  // Check value over the two frame bytes, shifted least significant first.
  function [15:0] crc2(input [6:0] cfg);
    reg [15:0] c, p;
    reg [15:0] d;
    integer i;
    begin
      c = start_val(cfg[3:2], cfg[6:4]);
      p = cfg[3:2] == 0 ? 16'h0014 : cfg[3:2] == 1 ? 16'h00B8 : 16'h8408;
      d = 16'h3CA5;
      for (i = 0; i < 16; i = i + 1) begin
        c = (c >> 1) ^ ((c[0] ^ d[i]) ? p : 16'h0000);
      end
      crc2 = (cfg[1] ? ~c : c) & wmask(cfg[3:2]);
    end
  endfunction
  // ==========================================================================
  // Scenario: send A5h 3Ch and judge the outgoing stream.
  task tx_frame(input [6:0] cfg);
    reg [15:0] c;
    integer k;
    begin
      wr(8'h2C, {1'b0, cfg});
      c = crc2(cfg);
      txq.delete();
      @(posedge clk) tx_frame_start <= 1;
      @(posedge clk) tx_frame_start <= 0;
      tx_byte_valid <= 1; tx_byte <= 8'hA5;
      @(posedge clk) tx_byte <= 8'h3C; tx_frame_end <= 1;
      @(posedge clk) tx_byte_valid <= 0; tx_frame_end <= 0;
      for (k = 0; k < 20 && tx_frame_done !== 1'b1; k = k + 1) @(posedge clk);
      @(posedge clk) #1;
      check(txq.size(), 2 + (cfg[0] ? (cfg[3] ? 2 : 1) : 0));
      check(txq[0], 8'hA5);
      check(txq[1], 8'h3C);
      if (cfg[0]) check(txq[2], c[7:0]);
      if (cfg[0] && cfg[3]) check(txq[3], c[15:8]);
    end
  endtask
  // Scenario: receive A5h 3Ch plus check bytes, optionally corrupted.
  task rx_frame(input [7:0] cfg, input bad);
    reg [15:0] c;
    integer e;
    begin
      wr(8'h2D, cfg);
      c = crc2(cfg[6:0]) ^ {15'h0000, bad};
      fq.delete();
      e = n_bad;
      @(posedge clk) rx_frame_start <= 1;
      @(posedge clk) rx_frame_start <= 0;
      rx_byte_valid <= 1; rx_byte <= 8'hA5;
      @(posedge clk) rx_byte <= 8'h3C;
      @(posedge clk) rx_byte <= c[7:0]; rx_byte_is_check <= 1;
      rx_frame_end <= !cfg[3];
      // The end pulse must ride on the last check byte, and only once.
      if (cfg[3]) begin
        @(posedge clk) rx_byte <= c[15:8];
        rx_frame_end <= 1;
      end
      @(posedge clk) rx_byte_valid <= 0; rx_frame_end <= 0;
      rx_byte_is_check <= 0;
      repeat (3) @(posedge clk);
      check(n_bad - e, cfg[0] & bad);
      check(fq.size(), 2 + (cfg[7] ? (cfg[3] ? 2 : 1) : 0));
      check(fq[0], 8'hA5);
      if (cfg[7]) check(fq[2], c[7:0]);
    end
  endtask
  // Closing report, the single exit of the run.
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence: registers, every width and start code, then interrupt.
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    rd(8'h2C); check(v, 8'h00);
    rd(8'h2D); check(v, 8'h00);
    wr(8'h2C, 8'hFF); rd(8'h2C); check(v, 8'h7F);
    wr(8'h2D, 8'hFF); rd(8'h2D); check(v, 8'hFF);
    rd(8'h10); check(v, 8'h00);
    for (t = 0; t < 3; t = t + 1) begin
      for (s = 0; s < 8; s = s + 1) begin
        tx_frame({s[2:0], t[1:0], s[0], 1'b1});
        rx_frame({s[1], s[2:0], t[1:0], s[0], 1'b1}, s[2]);
      end
    end
    tx_frame(7'h78);
    rx_frame(8'h78, 1'b1);
    // The reserved width code is run as the wide check.
    tx_frame(7'h7D);
    rx_frame(8'h7D, 1'b0);
    wr(8'h40, 8'h07); wr(8'h41, 8'h01);
    rx_frame(8'h09, 1'b1);
    #1 check(irq, 1'b1);
    wr(8'h41, 8'h00); #1 check(irq, 1'b0);
    wr(8'h41, 8'h01); #1 check(irq, 1'b1);
    rd(8'h40); check(v, 8'h05);
    rd(8'h41); check(v, 8'h01);
    wr(8'h40, 8'h01); #1 check(irq, 1'b0);
    conclude;
  end
endmodule
